// file: pdwc_clkdiv.sv
`timescale 1ns/100ps
// core clock enable: one pulse every 2**code cycles
module pdwc_clkdiv
  import pdwc_pkg::*;
(
  input  wire logic                 mclk_in,
  input  wire logic                 arst_n_in,
  input  wire logic                 run_in,
  input  wire logic [PLL_DIV_W-1:0] code_in,
  output logic                      core_en_out
);
  logic [6:0] cnt_q;
  logic [6:0] mask;

  assign mask        = 7'((8'h01 << code_in) - 8'h01);
  assign core_en_out = run_in && ((cnt_q & mask) == 7'h00);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= 7'h00;
    end else if (run_in) begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  a_div_rate : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      core_en_out && code_in == 3'h3 |=> (!core_en_out || code_in != 3'h3) [*7])
    else $error("divide by eight gave an early enable");
endmodule

// file: pdwc_pkg.sv
package pdwc_pkg;
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned POR_DELAY_MS    = 128;
  localparam int unsigned PLL_LOCK_US     = 1000;
  localparam int unsigned XTAL_START_MS   = 150;
  localparam int unsigned POR_CYCLES      = CLK_HZ / 1000 * POR_DELAY_MS;
  localparam int unsigned PLL_LOCK_CYCLES = CLK_HZ / 1000000 * PLL_LOCK_US;
  localparam int unsigned XTAL_CYCLES     = CLK_HZ / 1000 * XTAL_START_MS;
  localparam int unsigned CNT_W           = 32;

  // word byte addresses
  localparam logic [3:0] ADDR_PLL_CTL = 4'h0;
  localparam logic [3:0] ADDR_PWR_CTL = 4'h4;
  localparam logic [3:0] ADDR_IRQ_EN  = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hC;

  // pll control fields
  localparam int unsigned PLL_DIV_LSB  = 0;
  localparam int unsigned PLL_DIV_W    = 3;
  localparam int unsigned PLL_XPD_BIT  = 4;
  localparam int unsigned PLL_LOCK_BIT = 6;
  localparam logic [7:0]  PLL_CTL_RST  = 8'h03;
  // power control fields
  localparam int unsigned PWR_PD_BIT   = 1;
  localparam int unsigned PWR_EXT0_BIT = 5;
  localparam int unsigned PWR_SER_BIT  = 6;
  localparam logic [7:0]  PWR_CTL_RST  = 8'h00;
  // interrupt enable fields
  localparam int unsigned IEN_EXT0_BIT = 0;
  localparam int unsigned IEN_SPI_BIT  = 1;
  localparam int unsigned IEN_TIC_BIT  = 2;
  localparam logic [7:0]  IRQ_EN_RST   = 8'h00;
  // status fields
  localparam int unsigned ST_RUN_BIT   = 0;
  localparam int unsigned ST_PD_BIT    = 1;
  localparam int unsigned ST_XTAL_BIT  = 2;

  typedef enum logic [2:0] {
    PDWC_POR, PDWC_RUN, PDWC_PDOWN, PDWC_XTAL, PDWC_LOCK
  } pdwc_state_t;
endpackage

// file: pdwc_tb.sv
`timescale 1ns/100ps
module testbench;
  import pdwc_pkg::*;
  localparam int POR = 20;
  localparam int LCK = 10;
  localparam int XTL = 30;
  logic        mclk_in = 0;
  logic        arst_n_in = 0;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        interval_counter = 0;
  logic        tic_en = 0;
  logic        spi = 0;
  logic        ext0 = 0;
  logic        iack = 0;
  logic [31:0] rdat;
  logic        ack, rst_o, clk_en, osc, locked, wirq, resume;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [7:0]  q;

  pdwc_top #(.POR_CNT(POR), .LOCK_CNT(LCK), .XTAL_CNT(XTL)) dut (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .tic_irq_in(interval_counter), .tic_enabled_in(tic_en), .spi_irq_in(spi), .external_irq0_in(ext0),
    .irq_ack_in(iack), .core_reset_out(rst_o), .core_clk_en_out(clk_en), .osc32k_run_out(osc),
    .pll_locked_out(locked), .wake_irq_out(wirq), .resume_next_out(resume));

  always #12.5 mclk_in = ~mclk_in;

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      end_sim();
    end
  end

  task end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk_in);
  endtask

  task enter_pd(input logic [7:0] pll, input logic [7:0] pwr, input logic [7:0] ien);
    wb(1'b1, ADDR_PLL_CTL, pll, q);
    wb(1'b1, ADDR_IRQ_EN, ien, q);
    wb(1'b1, ADDR_PWR_CTL, pwr | (8'h01 << PWR_PD_BIT), q);
    wb(1'b0, ADDR_STATUS, 8'h00, q);
    check(q[ST_PD_BIT], 1);
  endtask

  // source raised on the edge before entry; counts edges until lock shows
  task wake_chk(input int lo, input int hi);
    int n, pulses;
    n = 0;
    pulses = 0;
    while (locked !== 1'b1 && n < hi + 5) begin
      @(posedge mclk_in);
      n++;
      pulses += (clk_en === 1'b1);
    end
    check(n >= lo && n <= hi, 1);
    check(pulses > 0, 1);
    check(wirq, 1);
    check(resume, 1);
    interval_counter <= 0;
    spi <= 0;
    ext0 <= 0;
    wb(1'b0, ADDR_PLL_CTL, 8'h00, q);
    check(q[PLL_LOCK_BIT], 1);
    iack <= 1'b1;
    @(posedge mclk_in);
    iack <= 1'b0;
    repeat (2) @(posedge mclk_in);
    check({wirq, resume}, 2'b00);
  endtask

  task t_por();
    int n;
    n = 0;
    while (rst_o === 1'b1 && n < POR + 10) begin
      @(posedge mclk_in);
      n++;
    end
    check(n >= POR - 1 && n <= POR + 2, 1);
    wb(1'b0, ADDR_PLL_CTL, 8'h00, q);
    check(q, PLL_CTL_RST | (8'h01 << PLL_LOCK_BIT));
    wb(1'b0, ADDR_PWR_CTL, 8'h00, q);
    check(q, PWR_CTL_RST);
    wb(1'b0, ADDR_IRQ_EN, 8'h00, q);
    check(q, IRQ_EN_RST);
    wb(1'b0, 4'h2, 8'h00, q);
    check(q, 8'h00);
  endtask

  task t_div();
    int pulses;
    for (int c = 3; c >= 0; c--) begin
      wb(1'b1, ADDR_PLL_CTL, 8'(c), q);
      pulses = 0;
      repeat (64) begin
        @(posedge mclk_in);
        pulses += (clk_en === 1'b1);
      end
      check(pulses, 64 >> c);
    end
  endtask

  task t_spi();
    int pulses;
    enter_pd(8'h00, 8'h01 << PWR_SER_BIT, 8'h00);
    @(posedge mclk_in);
    spi <= 1'b1;
    pulses = 0;
    repeat (20) begin
      @(posedge mclk_in);
      pulses += (clk_en === 1'b1);
    end
    check(pulses, 0);
    check(wirq, 0);
    spi <= 1'b0;
    wb(1'b1, ADDR_IRQ_EN, 8'h01 << IEN_SPI_BIT, q);
    spi <= 1'b1;
    wake_chk(LCK, LCK + 5);
  endtask

  task t_tic();
    enter_pd(8'h00, 8'h00, 8'h01 << IEN_TIC_BIT);
    check(osc, 1);
    interval_counter <= 1'b1;
    repeat (10) @(posedge mclk_in);
    check(wirq, 0);
    check(clk_en, 0);
    tic_en <= 1'b1;
    wake_chk(LCK, LCK + 5);
  endtask

  task t_ext0();
    enter_pd(8'h01 << PLL_XPD_BIT, 8'h01 << PWR_EXT0_BIT, 8'h01 << IEN_EXT0_BIT);
    check(osc, 0);
    ext0 <= 1'b1;
    wake_chk(XTL + LCK, XTL + LCK + 6);
  endtask

  initial begin
    repeat (4) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    t_por();
    t_div();
    t_spi();
    t_tic();
    t_ext0();
    end_sim();
  end
endmodule

// file: pdwc_top.sv
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module pdwc_top
  import pdwc_pkg::*;
#(
  parameter int unsigned POR_CNT  = POR_CYCLES,
  parameter int unsigned LOCK_CNT = PLL_LOCK_CYCLES,
  parameter int unsigned XTAL_CNT = XTAL_CYCLES
)(
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        tic_irq_in,
  input  wire logic        tic_enabled_in,
  input  wire logic        spi_irq_in,
  input  wire logic        external_irq0_in,
  input  wire logic        irq_ack_in,
  output logic             core_reset_out,
  output logic             core_clk_en_out,
  output logic             osc32k_run_out,
  output logic             pll_locked_out,
  output logic             wake_irq_out,
  output logic             resume_next_out
);
  pdwc_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0] pll_control_reg_q;
  logic [7:0] power_control_reg_q;
  logic [7:0] irq_en_q;
  logic       xtal_was_off_q;
  logic       wake_pend_q;
  logic       resume_q;
  logic       wake_tic;
  logic       wake_spi;
  logic       wake_ext0;
  logic       wake_any;
  logic       wr_stb;
  logic       bus_req;
  logic       pd_req;

  function automatic logic [7:0] wb_merge(input logic [7:0] old, input logic [31:0] d, input logic [3:0] sel);
    wb_merge = sel[0] ? d[7:0] : old;
  endfunction

  assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_stb  = bus_req && wb_we_in;
  assign pd_req  = wr_stb && wb_adr_in == ADDR_PWR_CTL && wb_sel_in[0] && wb_dat_in[PWR_PD_BIT];

  // oscillator stays up unless software asked to drop the crystal and the sequencer is in power-down
  assign osc32k_run_out = !(pll_control_reg_q[PLL_XPD_BIT] && state_q == PDWC_PDOWN);
  assign wake_tic  = tic_irq_in && tic_enabled_in && irq_en_q[IEN_TIC_BIT] && osc32k_run_out;
  assign wake_spi  = spi_irq_in && irq_en_q[IEN_SPI_BIT] && power_control_reg_q[PWR_SER_BIT];
  assign wake_ext0 = external_irq0_in && irq_en_q[IEN_EXT0_BIT] && power_control_reg_q[PWR_EXT0_BIT];
  assign wake_any  = wake_tic || wake_spi || wake_ext0;

  assign core_reset_out  = state_q == PDWC_POR;
  assign pll_locked_out  = pll_control_reg_q[PLL_LOCK_BIT];
  assign resume_next_out = resume_q;
  assign wake_irq_out    = wake_pend_q;

  pdwc_clkdiv u_div (
    .mclk_in     (mclk_in),
    .arst_n_in   (arst_n_in),
    .run_in      (state_q != PDWC_POR && state_q != PDWC_PDOWN),
    .code_in     (pll_control_reg_q[PLL_DIV_LSB +: PLL_DIV_W]),
    .core_en_out (core_clk_en_out)
  );

  // sequencer; clock runs unlocked during xtal and lock phases
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= PDWC_POR;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        PDWC_POR: begin
          if (cnt_q >= CNT_W'(POR_CNT - 1)) begin
            state_q <= PDWC_RUN;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PDWC_RUN: begin
          if (pd_req) begin
            state_q <= PDWC_PDOWN;
          end
        end
        PDWC_PDOWN: begin
          cnt_q <= '0;
          if (wake_any) begin
            state_q <= xtal_was_off_q ? PDWC_XTAL : PDWC_LOCK;
          end
        end
        PDWC_XTAL: begin
          if (cnt_q >= CNT_W'(XTAL_CNT - 1)) begin
            state_q <= PDWC_LOCK;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PDWC_LOCK: begin
          if (cnt_q >= CNT_W'(LOCK_CNT - 1)) begin
            state_q <= PDWC_RUN;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
          if (pd_req) begin
            state_q <= PDWC_PDOWN;
          end
        end
        default: state_q <= PDWC_POR;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      xtal_was_off_q <= 1'b0;
    end else if (state_q == PDWC_PDOWN) begin
      xtal_was_off_q <= xtal_was_off_q | pll_control_reg_q[PLL_XPD_BIT];
    end else if (state_q == PDWC_RUN) begin
      xtal_was_off_q <= 1'b0;
    end
  end

  // wake interrupt and resume marker held until the core acknowledges; set wins
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wake_pend_q <= 1'b0;
      resume_q    <= 1'b0;
    end else if (state_q == PDWC_PDOWN && wake_any) begin
      wake_pend_q <= 1'b1;
      resume_q    <= 1'b1;
    end else if (irq_ack_in) begin
      wake_pend_q <= 1'b0;
      resume_q    <= 1'b0;
    end
  end

  // registers; lock bit is hardware owned
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pll_control_reg_q   <= PLL_CTL_RST;
      power_control_reg_q <= PWR_CTL_RST;
      irq_en_q            <= IRQ_EN_RST;
    end else begin
      if (wr_stb && wb_adr_in == ADDR_PLL_CTL) begin
        pll_control_reg_q <= wb_merge(pll_control_reg_q, wb_dat_in, wb_sel_in);
      end
      pll_control_reg_q[PLL_LOCK_BIT] <= (state_q == PDWC_RUN);
      if (wr_stb && wb_adr_in == ADDR_PWR_CTL) begin
        power_control_reg_q <= wb_merge(power_control_reg_q, wb_dat_in, wb_sel_in);
      end
      power_control_reg_q[PWR_PD_BIT] <= 1'b0;
      if (wr_stb && wb_adr_in == ADDR_IRQ_EN) begin
        irq_en_q <= wb_merge(irq_en_q, wb_dat_in, wb_sel_in);
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end else begin
      wb_ack_out <= bus_req;
      if (bus_req && !wb_we_in) begin
        unique case (wb_adr_in)
          ADDR_PLL_CTL: wb_dat_out <= {24'h000000, pll_control_reg_q};
          ADDR_PWR_CTL: wb_dat_out <= {24'h000000, power_control_reg_q};
          ADDR_IRQ_EN:  wb_dat_out <= {24'h000000, irq_en_q};
          ADDR_STATUS:  wb_dat_out <= {29'h00000000, xtal_was_off_q, state_q == PDWC_PDOWN, state_q == PDWC_RUN};
          default:      wb_dat_out <= 32'h00000000;
        endcase
      end
    end
  end

  a_lock_after_wake : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      $rose(state_q == PDWC_LOCK) |-> !pll_locked_out [*2])
    else $error("lock reported too early");
  a_pd_holds : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN && !wake_any |=> state_q == PDWC_PDOWN)
    else $error("left power-down without a wake source");
  a_pd_no_clock : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN |-> !core_clk_en_out)
    else $error("core clock ran in power-down");
  a_osc_kept : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      !pll_control_reg_q[PLL_XPD_BIT] |-> osc32k_run_out)
    else $error("oscillator stopped with crystal enabled");
  a_spi_wake : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN && wake_spi |=> state_q != PDWC_PDOWN && wake_irq_out)
    else $error("spi wake missed");
  a_ext0_wake : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN && wake_ext0 |=> resume_next_out)
    else $error("ext0 wake missed");
  a_tic_wake : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN && wake_tic && !irq_ack_in |=> wake_irq_out)
    else $error("interval wake missed");
  a_xtal_path : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN && wake_any && xtal_was_off_q |=> state_q == PDWC_XTAL)
    else $error("crystal start-up skipped");
  a_por_reset : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      $fell(core_reset_out) |-> $past(cnt_q) == CNT_W'(POR_CNT - 1))
    else $error("reset released at wrong count");

  // reset delay and oscillator checks
  a_por_no_clock : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      core_reset_out |-> !core_clk_en_out)
    else $error("core clock ran during reset delay");

  a_por_unlocked : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      core_reset_out |-> !pll_locked_out)
    else $error("lock shown during reset delay");

  a_osc_awake : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q != PDWC_PDOWN |-> osc32k_run_out)
    else $error("oscillator stopped outside power-down");

  a_osc_dropped : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN && pll_control_reg_q[PLL_XPD_BIT] |-> !osc32k_run_out)
    else $error("crystal kept running when asked off");

  // wake gating, wake interrupt, sequencer and bus acknowledge checks
  a_tic_gated : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN && !irq_en_q[IEN_TIC_BIT] && !wake_spi && !wake_ext0 |=> state_q == PDWC_PDOWN)
    else $error("disabled interval source woke the device");

  a_spi_gated : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN && !power_control_reg_q[PWR_SER_BIT] && !wake_tic && !wake_ext0
      |=> state_q == PDWC_PDOWN)
    else $error("spi woke without serial wake enable");

  a_ext0_gated : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN && !power_control_reg_q[PWR_EXT0_BIT] && !wake_tic && !wake_spi
      |=> state_q == PDWC_PDOWN)
    else $error("ext0 woke without its wake enable");

  a_resume_pair : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      wake_irq_out |-> resume_next_out)
    else $error("wake interrupt without resume marker");

  a_wake_sticky : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      wake_irq_out && !irq_ack_in |=> wake_irq_out)
    else $error("wake interrupt dropped before service");

  a_pd_entry : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_RUN && pd_req |=> state_q == PDWC_PDOWN)
    else $error("power-down request ignored");

  a_direct_lock : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN && wake_any && !xtal_was_off_q |=> state_q == PDWC_LOCK)
    else $error("wake skipped the lock phase");

  a_xtal_done : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_XTAL && cnt_q == CNT_W'(XTAL_CNT - 1) |=> state_q == PDWC_LOCK)
    else $error("crystal phase did not end on time");

  a_xtal_flag : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_PDOWN && pll_control_reg_q[PLL_XPD_BIT] |=> xtal_was_off_q)
    else $error("crystal-off flag not recorded");

  a_lock_done : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_LOCK && cnt_q == CNT_W'(LOCK_CNT - 1) && !pd_req |=> state_q == PDWC_RUN)
    else $error("lock phase did not end on time");

  a_lock_sets : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_RUN |=> pll_locked_out)
    else $error("lock bit missing in run");

  a_lock_clock : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_LOCK && pll_control_reg_q[PLL_DIV_LSB +: PLL_DIV_W] == '0 |-> core_clk_en_out)
    else $error("core stalled while waiting for lock");

  a_run_no_reset : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state_q == PDWC_RUN |-> !core_reset_out)
    else $error("core held in reset while running");

  a_ack_pulse : assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      wb_ack_out |=> !wb_ack_out)
    else $error("bus acknowledge longer than one cycle");
endmodule
